// ---- verilog/safp_pkg.sv ----
// Constants and types for the serial audio frame port
`default_nettype none
package safp_pkg;
    // Register byte offsets
    localparam int unsigned SAFP_AW = 5;
    localparam logic [4:0] SAFP_A_CTRL = 5'h00;
    localparam logic [4:0] SAFP_A_STAT = 5'h04;
    localparam logic [4:0] SAFP_A_DATA = 5'h08;
    localparam logic [4:0] SAFP_A_FRAME = 5'h0c;
    localparam logic [4:0] SAFP_A_TXCH = 5'h10;
    localparam logic [4:0] SAFP_A_RXCH = 5'h14;
    // Field positions
    localparam int unsigned SAFP_CTRL_W = 8;
    localparam int unsigned SAFP_TXCLR = 8;
    localparam int unsigned SAFP_RXCLR = 9;
    localparam int unsigned SAFP_S_TXERR = 4;
    localparam int unsigned SAFP_S_RXERR = 5;
    localparam int unsigned SAFP_FRAME_W = 20;
    localparam int unsigned SAFP_I_DIN = 0;
    localparam int unsigned SAFP_I_FS = 1;
    localparam int unsigned SAFP_I_BCLK = 2;
    localparam int unsigned SAFP_I_MCLK = 3;
    // Sizes and counts
    localparam int unsigned SAFP_FIFO_AW = 4;
    localparam logic [4:0] SAFP_MSB = 5'h1f;
    localparam logic [4:0] SAFP_MINW_M1 = 5'h07;
    // Control fields, one channel descriptor, frame shape
    typedef struct packed {
        logic pdm;
        logic fs_inv;
        logic clk_inv;
        logic fs_slave;
        logic clk_slave;
        logic rxon;
        logic txon;
        logic en;
    } safp_ctrl_t;
    typedef struct packed {
        logic en;
        logic [4:0] wid_m1;
        logic [9:0] pos;
    } safp_chan_t;
    typedef struct packed {
        logic [9:0] fs_len;
        logic [9:0] frame_len;
    } safp_frame_t;
    typedef enum logic [1:0] {
        SAFP_OFF = 2'b00,
        SAFP_SYNC = 2'b01,
        SAFP_RUN = 2'b11
    } safp_fsm_t;
    // Reset values
    localparam safp_ctrl_t SAFP_CTRL_RST = '0;
    localparam safp_frame_t SAFP_FRAME_RST = '0;
endpackage
`default_nettype wire

// ---- verilog/safp_mem.sv ----
// Word store with registered read data for the port queues
`timescale 1ns/1ns
`default_nettype none
module safp_mem #(
    parameter int unsigned W = 32,
    parameter int unsigned AW = 4
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem_r [0:(1<<AW)-1];
    logic [W-1:0] rdata_r;

    // Write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
        rdata_r <= mem_r[raddr];
    end

    assign rdata = rdata_r;
endmodule
`default_nettype wire

// ---- verilog/safp_top.sv ----
// Serial audio frame port: register slave, frame engine and queues
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Four link signals: bit clock, frame sync, serial in, serial out.
// - One data bit per bit-clock period on each single data line.
// - Channel words travel most significant bit first.
// - Frame sync length, pulse length and polarity set by software.
// - One or two channels per direction, chosen independently.
// - Channel width anywhere from eight to thirty-two bits.
// - Channel start position programmable; channels of a direction never overlap (not checked by the logic; channel 2 wins where both match).
// - Transmit and receive channel formats held separately.
// - Bit clock may be asynchronous; crossings must be safe.
// - Optional bit clock inversion swaps drive and sample edges.
// - Bit clock and frame sync directions selected independently.
// - Receive may take two density-modulated microphones instead; output unchanged.
// - Separate queues for transmit and receive data.
// - Two channels share one queue per direction, words alternating.
// - Queues serviced by polling or DMA requests.
// - Outputs change on rising bit-clock edge, inputs sampled on falling edge.
// - Clock select zero drives bit clock from master clock; one accepts it.
// - External frame starts where sync is sampled high after low.
// - Underflow sends zeros, overflow drops samples; error flag set, keep running.
module safp_top import safp_pkg::*; #(
    parameter int unsigned FIFO_AW = SAFP_FIFO_AW
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [SAFP_AW-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic MASTER_CLK,
    input wire logic BIT_CLK_I,
    output logic BIT_CLK_O,
    output logic BIT_CLK_OE_N,
    input wire logic FRAME_SYNC_LINE_I,
    output logic FRAME_SYNC_LINE_O,
    output logic FRAME_SYNC_LINE_OE_N,
    input wire logic SER_DIN,
    output logic SER_DOUT,
    output logic TX_REQ,
    output logic RX_REQ
);
    localparam logic [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
    localparam logic [FIFO_AW:0] ONE = {{FIFO_AW{1'b0}}, 1'b1};

    typedef struct packed {
        safp_ctrl_t ctrl;
        safp_frame_t frame;
        safp_chan_t [1:0] txch;
        safp_chan_t [1:0] rxch;
        logic [3:0] sy1;
        logic [3:0] sy2;
        logic bclk_prev;
        logic mclk_prev;
        logic gen_clk;
        logic fs_prev;
        safp_fsm_t fsm;
        logic [9:0] cnt;
        logic txgo;
        logic [31:0] tx_sh;
        logic [31:0] rx_sh;
        logic [31:0] pdm_sh;
        logic [4:0] pdm_cnt;
        logic pdm_pend;
        logic dout;
        logic fs_out;
        logic [FIFO_AW-1:0] tx_wp;
        logic [FIFO_AW-1:0] tx_rp;
        logic [FIFO_AW-1:0] rx_wp;
        logic [FIFO_AW-1:0] rx_rp;
        logic [FIFO_AW:0] tx_n;
        logic [FIFO_AW:0] rx_n;
        logic tx_fresh;
        logic rx_fresh;
        logic tx_err;
        logic rx_err;
        logic [31:0] rdata;
    } safp_state_t;

    safp_state_t s_r;
    safp_state_t s_nxt;
    logic tx_push, tx_pop, rx_push, rx_pop, tx_load, rx_want, tx_msb;
    logic [31:0] rx_word, tx_rdata, rx_rdata;
    logic bclk, rise, fall, fs_in, start_slv, run, live_fall;
    logic tx_full, rx_full, tx_avail, rx_avail;
    logic [9:0] nc;

    // Width clamped to the legal eight-bit minimum
    function automatic logic [4:0] eff_m1(input safp_chan_t c);
        return (c.wid_m1 < SAFP_MINW_M1) ? SAFP_MINW_M1 : c.wid_m1;
    endfunction

    // Last bit position of a channel
    function automatic logic [10:0] last_bit(input safp_chan_t c);
        return {1'b0, c.pos} + {6'h00, eff_m1(c)};
    endfunction

    // True while frame index i lies inside the channel
    function automatic logic in_chan(input safp_chan_t c, input logic [9:0] i);
        return c.en && (i >= c.pos) && ({1'b0, i} <= last_bit(c));
    endfunction

    // Queue storage
    safp_mem #(.W(32), .AW(FIFO_AW)) u_txq (
        .clk(SYS_CLK),
        .we(tx_push),
        .waddr(s_r.tx_wp),
        .wdata(WDATA),
        .raddr(s_nxt.tx_rp),
        .rdata(tx_rdata)
    );
    safp_mem #(.W(32), .AW(FIFO_AW)) u_rxq (
        .clk(SYS_CLK),
        .we(rx_push),
        .waddr(s_r.rx_wp),
        .wdata(rx_word),
        .raddr(s_nxt.rx_rp),
        .rdata(rx_rdata)
    );

    // Queue status and bit clock edge finding
    assign tx_full = (s_r.tx_n == DEPTH);
    assign rx_full = (s_r.rx_n == DEPTH);
    assign tx_avail = (s_r.tx_n != '0) && !s_r.tx_fresh;
    assign rx_avail = (s_r.rx_n != '0) && !s_r.rx_fresh;
    assign bclk = (s_r.ctrl.clk_slave ? s_r.sy2[SAFP_I_BCLK] : s_r.gen_clk)
        ^ s_r.ctrl.clk_inv;
    assign rise = bclk && !s_r.bclk_prev;
    assign fall = !bclk && s_r.bclk_prev;
    assign run = s_r.ctrl.en && (s_r.ctrl.txon || s_r.ctrl.rxon);
    assign nc = (s_r.cnt >= s_r.frame.frame_len) ? 10'h000 : s_r.cnt + 10'h001;
    assign fs_in = s_r.sy2[SAFP_I_FS] ^ s_r.ctrl.fs_inv;
    assign start_slv = s_r.ctrl.fs_slave && fall && fs_in && !s_r.fs_prev;
    assign live_fall = fall && ((s_r.fsm == SAFP_RUN)
        || (s_r.fsm == SAFP_SYNC && start_slv));

    // Next-state logic
    always_comb begin
        logic [31:0] word;
        logic [31:0] sh;
        logic [9:0] idx;
        word = '0;
        sh = '0;
        idx = start_slv ? 10'h000 : s_r.cnt;
        s_nxt = s_r;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_load = 1'b0;
        rx_want = 1'b0;
        tx_msb = 1'b0;
        rx_word = '0;
        // Two-stage synchronisers on all link inputs
        s_nxt.sy1 = {MASTER_CLK, BIT_CLK_I, FRAME_SYNC_LINE_I, SER_DIN};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.bclk_prev = bclk;
        s_nxt.mclk_prev = s_r.sy2[SAFP_I_MCLK];
        if (fall) begin
            s_nxt.fs_prev = fs_in;
        end
        // Bit clock from master clock in clock master mode
        if (!s_r.ctrl.en || s_r.ctrl.clk_slave) begin
            s_nxt.gen_clk = 1'b0;
        end else if (s_r.sy2[SAFP_I_MCLK] && !s_r.mclk_prev) begin
            s_nxt.gen_clk = !s_r.gen_clk;
        end
        // Register writes
        if (WR) begin
            case (ADDR)
                SAFP_A_CTRL: s_nxt.ctrl = safp_ctrl_t'(WDATA[SAFP_CTRL_W-1:0]);
                SAFP_A_STAT: begin
                    if (WDATA[SAFP_S_TXERR]) begin
                        s_nxt.tx_err = 1'b0;
                    end
                    if (WDATA[SAFP_S_RXERR]) begin
                        s_nxt.rx_err = 1'b0;
                    end
                end
                SAFP_A_FRAME: s_nxt.frame = safp_frame_t'(WDATA[SAFP_FRAME_W-1:0]);
                SAFP_A_TXCH: s_nxt.txch = WDATA;
                SAFP_A_RXCH: s_nxt.rxch = WDATA;
                SAFP_A_DATA: tx_push = !tx_full;
                default: ;
            endcase
        end
        // Register reads, data one cycle later
        s_nxt.rdata = '0;
        if (RD) begin
            case (ADDR)
                SAFP_A_CTRL: s_nxt.rdata = {24'h000000, s_r.ctrl};
                SAFP_A_STAT: s_nxt.rdata = {24'h000000, s_r.fsm, s_r.rx_err, s_r.tx_err,
                    rx_full, (s_r.rx_n == '0), tx_full, (s_r.tx_n == '0)};
                SAFP_A_FRAME: s_nxt.rdata = {12'h000, s_r.frame};
                SAFP_A_TXCH: s_nxt.rdata = s_r.txch;
                SAFP_A_RXCH: s_nxt.rdata = s_r.rxch;
                SAFP_A_DATA: begin
                    s_nxt.rdata = rx_avail ? rx_rdata : 32'h00000000;
                    rx_pop = rx_avail;
                end
                default: s_nxt.rdata = '0;
            endcase
        end
        // Frame state machine
        case (s_r.fsm)
            SAFP_OFF: begin
                s_nxt.dout = 1'b0;
                s_nxt.fs_out = s_r.ctrl.fs_inv;
                s_nxt.txgo = 1'b0;
                s_nxt.pdm_cnt = '0;
                s_nxt.pdm_pend = 1'b0;
                if (run) begin
                    s_nxt.fsm = SAFP_SYNC;
                    s_nxt.cnt = s_r.frame.frame_len;
                end
            end
            SAFP_SYNC: begin
                if (!run) begin
                    s_nxt.fsm = SAFP_OFF;
                end else if (s_r.ctrl.fs_slave ? start_slv : rise) begin
                    s_nxt.fsm = SAFP_RUN;
                end
            end
            SAFP_RUN: begin
                if (!run) begin
                    s_nxt.fsm = SAFP_OFF;
                end
            end
            default: s_nxt.fsm = SAFP_OFF;
        endcase
        // Driving edge: counter, frame sync and transmit bits
        if (s_r.fsm == SAFP_RUN && rise) begin
            s_nxt.cnt = nc;
            if (!s_r.ctrl.fs_slave) begin
                s_nxt.fs_out = (nc < s_r.frame.fs_len) ^ s_r.ctrl.fs_inv;
            end
            s_nxt.txgo = s_r.txgo || (nc == 10'h000);
            s_nxt.dout = 1'b0;
            for (int k = 0; k < 2; k++) begin
                if (s_r.ctrl.txon && s_nxt.txgo && in_chan(s_r.txch[k], nc)) begin
                    if (nc == s_r.txch[k].pos) begin
                        tx_load = 1'b1;
                        tx_msb = tx_rdata[eff_m1(s_r.txch[k])];
                        word = tx_avail ? tx_rdata : 32'h00000000;
                        word = word << (SAFP_MSB - eff_m1(s_r.txch[k]));
                        s_nxt.dout = word[31];
                        s_nxt.tx_sh = word << 1;
                        tx_pop = tx_avail;
                        if (!tx_avail) begin
                            s_nxt.tx_err = 1'b1;
                        end
                    end else begin
                        s_nxt.dout = s_r.tx_sh[31];
                        s_nxt.tx_sh = s_r.tx_sh << 1;
                    end
                end
            end
        end
        // Sampling edge: resync counter and gather receive bits
        if (start_slv && s_r.fsm != SAFP_OFF) begin
            s_nxt.cnt = 10'h000;
        end
        if (s_r.ctrl.rxon && !s_r.ctrl.pdm && live_fall) begin
            for (int k = 0; k < 2; k++) begin
                if (in_chan(s_r.rxch[k], idx)) begin
                    sh = (idx == s_r.rxch[k].pos) ? {31'h0, s_r.sy2[SAFP_I_DIN]}
                        : {s_r.rx_sh[30:0], s_r.sy2[SAFP_I_DIN]};
                    s_nxt.rx_sh = sh;
                    if ({1'b0, idx} == last_bit(s_r.rxch[k])) begin
                        rx_want = 1'b1;
                        rx_word = sh;
                    end
                end
            end
        end
        // Density-modulated microphones: channel 1 on fall, channel 2 on rise
        if (s_r.ctrl.rxon && s_r.ctrl.pdm && s_r.fsm != SAFP_OFF) begin
            if (fall) begin
                s_nxt.rx_sh = {s_r.rx_sh[30:0], s_r.sy2[SAFP_I_DIN]};
                s_nxt.pdm_cnt = s_r.pdm_cnt + 5'h01;
                if (s_r.pdm_cnt == SAFP_MSB) begin
                    rx_want = 1'b1;
                    rx_word = s_nxt.rx_sh;
                    s_nxt.pdm_pend = s_r.rxch[1].en;
                end
            end
            if (rise) begin
                s_nxt.pdm_sh = {s_r.pdm_sh[30:0], s_r.sy2[SAFP_I_DIN]};
                if (s_r.pdm_pend) begin
                    rx_want = 1'b1;
                    rx_word = s_nxt.pdm_sh;
                    s_nxt.pdm_pend = 1'b0;
                end
            end
        end
        // Overflow drops the word and flags it
        if (rx_want) begin
            if (rx_full) begin
                s_nxt.rx_err = 1'b1;
            end else begin
                rx_push = 1'b1;
            end
        end
        // Queue pointers and counts
        s_nxt.tx_wp = s_r.tx_wp + FIFO_AW'(tx_push);
        s_nxt.tx_rp = s_r.tx_rp + FIFO_AW'(tx_pop);
        s_nxt.tx_n = s_r.tx_n + (FIFO_AW+1)'(tx_push) - (FIFO_AW+1)'(tx_pop);
        s_nxt.tx_fresh = tx_push && (s_r.tx_n == '0 || (s_r.tx_n == ONE && tx_pop));
        s_nxt.rx_wp = s_r.rx_wp + FIFO_AW'(rx_push);
        s_nxt.rx_rp = s_r.rx_rp + FIFO_AW'(rx_pop);
        s_nxt.rx_n = s_r.rx_n + (FIFO_AW+1)'(rx_push) - (FIFO_AW+1)'(rx_pop);
        s_nxt.rx_fresh = rx_push && (s_r.rx_n == '0 || (s_r.rx_n == ONE && rx_pop));
        // Queue clears win over traffic
        if (WR && ADDR == SAFP_A_CTRL && WDATA[SAFP_TXCLR]) begin
            s_nxt.tx_wp = '0;
            s_nxt.tx_rp = '0;
            s_nxt.tx_n = '0;
            s_nxt.tx_fresh = 1'b0;
        end
        if (WR && ADDR == SAFP_A_CTRL && WDATA[SAFP_RXCLR]) begin
            s_nxt.rx_wp = '0;
            s_nxt.rx_rp = '0;
            s_nxt.rx_n = '0;
            s_nxt.rx_fresh = 1'b0;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pin and service outputs
    assign BIT_CLK_O = s_r.gen_clk;
    assign BIT_CLK_OE_N = !(s_r.ctrl.en && !s_r.ctrl.clk_slave);
    assign FRAME_SYNC_LINE_O = s_r.fs_out;
    assign FRAME_SYNC_LINE_OE_N = !(s_r.ctrl.en && !s_r.ctrl.fs_slave);
    assign SER_DOUT = s_r.dout;
    assign RDATA = s_r.rdata;
    assign TX_REQ = s_r.ctrl.en && s_r.ctrl.txon && !tx_full;
    assign RX_REQ = s_r.ctrl.en && rx_avail;

    // Checks
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    idle_dout_a: assert property (s_r.fsm == SAFP_OFF |=> !SER_DOUT)
        else $error("serial out active while off");
    clr_empty_a: assert property ((WR && ADDR == SAFP_A_CTRL && WDATA[SAFP_TXCLR])
        |=> s_r.tx_n == '0)
        else $error("transmit clear left words");
    gen_hold_a: assert property (s_r.ctrl.clk_slave |=> !BIT_CLK_O)
        else $error("bit clock driven in slave mode");
    tx_under_a: assert property ((tx_load && !tx_avail) |=> (s_r.tx_err && !SER_DOUT))
        else $error("underflow not zero or unflagged");
    rx_over_a: assert property ((rx_want && rx_full && !WR && !RD)
        |=> (s_r.rx_err && s_r.rx_n == $past(s_r.rx_n)))
        else $error("overflow not dropped");
    msb_first_a: assert property ((tx_load && tx_avail) |=> SER_DOUT == $past(tx_msb))
        else $error("first bit not msb");
    fs_gen_a: assert property ((rise && s_r.fsm == SAFP_RUN && !s_r.ctrl.fs_slave
        && nc == 10'h000 && s_r.frame.fs_len != 10'h000)
        |=> FRAME_SYNC_LINE_O != $past(s_r.ctrl.fs_inv))
        else $error("frame sync not active at frame start");
    fs_lock_a: assert property ((s_r.fsm == SAFP_SYNC && start_slv && run)
        |=> (s_r.fsm == SAFP_RUN && s_r.cnt == 10'h000))
        else $error("no lock on frame sync");
    dout_edge_a: assert property ((s_r.fsm == SAFP_RUN && !rise) |=> $stable(SER_DOUT))
        else $error("serial out moved off the drive edge");
    depth_a: assert property (s_r.tx_n <= DEPTH && s_r.rx_n <= DEPTH)
        else $error("queue count past depth");

    two_chan_c: cover property (rx_push && s_r.rxch[1].en && s_r.rx_sh != '0);
    under_c: cover property (tx_load && !tx_avail);
    lock_c: cover property (s_r.fsm == SAFP_SYNC && start_slv);
    pdm_c: cover property (rx_push && s_r.ctrl.pdm);
endmodule
`default_nettype wire

// ---- testbench/safp_codec.sv ----
// Behavioural codec that makes bit clock and frame sync for the port in slave mode
`timescale 1ns/1ns
`default_nettype none
module safp_codec #(
    parameter int HALF_NS = 40
) (
    input wire logic run,
    input wire logic [31:0] tx_word,
    input wire logic dout,
    output logic bclk,
    output logic fs,
    output logic din,
    output logic [31:0] rx_word,
    output logic [15:0] frames
);
    logic [31:0] sh;
    logic [31:0] cap;
    // Frames of 32 bits while run is high; clock stands still otherwise
    initial begin
        bclk = 1'b0;
        fs = 1'b0;
        din = 1'b0;
        rx_word = 32'h0;
        frames = 16'h0;
        cap = 32'h0;
        forever begin
            if (run !== 1'b1) begin
                din = ~din; // Released line keeps moving
                #HALF_NS;
            end else begin
                sh = tx_word;
                for (int i = 0; i < 32; i++) begin
                    bclk = 1'b1;
                    fs = (i == 0);
                    din = sh[31 - i];
                    #HALF_NS;
                    bclk = 1'b0;
                    cap[31 - i] = dout;
                    if (i == 31) begin
                        rx_word = cap;
                        frames = frames + 16'h1;
                    end
                    #HALF_NS;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/serial_audio_frame_port_test.sv ----
// Self-checking bench for the serial audio frame port
`timescale 1ns/1ns
`default_nettype none
module serial_audio_frame_port_test import safp_pkg::*;;
    localparam int DEPTH = 4;
    logic sys_clk, reset_n, wr, rd, mclk, run, started;
    logic [SAFP_AW-1:0] addr;
    logic [31:0] wdata, rdata, c_tx, c_rx, d, x;
    logic bclk_o, bclk_oe_n, fs_o, fs_oe_n, dout, tx_req, rx_req, c_bclk, c_fs, c_din;
    logic [15:0] frames;
    logic [31:0] exp_tx[$];
    logic [15:0] exp_rx[$];
    int bad_count, n_compared, cyc, seed, k, m, mdiv, n_bclk, n_fs, n_dout;
    wire logic bclk_w = bclk_oe_n ? c_bclk : bclk_o;
    wire logic fs_w = fs_oe_n ? c_fs : fs_o;
    safp_top #(.FIFO_AW(2)) safp_top_i (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MASTER_CLK(mclk), .BIT_CLK_I(bclk_w),
        .BIT_CLK_O(bclk_o), .BIT_CLK_OE_N(bclk_oe_n), .FRAME_SYNC_LINE_I(fs_w),
        .FRAME_SYNC_LINE_O(fs_o), .FRAME_SYNC_LINE_OE_N(fs_oe_n), .SER_DIN(c_din),
        .SER_DOUT(dout), .TX_REQ(tx_req), .RX_REQ(rx_req));
    safp_codec safp_codec_i (.run(run), .tx_word(c_tx), .dout(dout), .bclk(c_bclk),
        .fs(c_fs), .din(c_din), .rx_word(c_rx), .frames(frames));
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Master clock at 40 ns, timeout and edge counters
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        mdiv <= (mdiv == 4) ? 0 : mdiv + 1;
        if (mdiv == 4) mclk <= ~mclk;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end
    always @(posedge bclk_o) n_bclk++;
    always @(posedge fs_o) n_fs++;
    always @(posedge dout) n_dout++;
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr_reg(input logic [SAFP_AW-1:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [SAFP_AW-1:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // New codec word each frame; each frame the codec captures is checked once a nonzero one has been seen
    always @(frames) begin
        c_tx = $random(seed);
        exp_rx.push_back(c_tx[31:16]);
        exp_rx.push_back(c_tx[15:0]);
        if (c_rx !== 32'h0) started = 1'b1;
        if (started && exp_tx.size() >= 2) begin
            chk("dout frame", {exp_tx[0][15:0], exp_tx[1][15:0]}, c_rx);
            void'(exp_tx.pop_front());
            void'(exp_tx.pop_front());
        end else if (started) begin
            chk("underflow frame", 32'h0, c_rx);
        end
    end
    // Main sequence
    initial begin
        seed = 32'haa60;
        {reset_n, wr, rd, mclk, run, started} = 6'h0;
        addr = 5'h0;
        wdata = 32'h0;
        {bad_count, n_compared, cyc, mdiv, n_bclk, n_fs, n_dout} = '0;
        c_tx = $random(seed);
        exp_rx.push_back(c_tx[31:16]);
        exp_rx.push_back(c_tx[15:0]);
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        chk("pin enables", 32'h3, {30'h0, bclk_oe_n, fs_oe_n});
        chk("dout idle", 32'h0, {31'h0, dout});
        rd_reg(SAFP_A_CTRL, d);
        chk("ctrl reset", 32'h0, d);
        rd_reg(SAFP_A_STAT, d);
        chk("stat reset", 32'h5, d);
        rd_reg(5'h18, d);
        chk("unmapped", 32'h0, d);
        rd_reg(SAFP_A_DATA, d);
        chk("empty pop", 32'h0, d);
        wr_reg(SAFP_A_CTRL, 32'h40);
        repeat (2) @(negedge sys_clk);
        chk("sync polarity", 32'h1, {31'h0, fs_o});
        for (k = 0; k <= DEPTH; k++) wr_reg(SAFP_A_DATA, $random(seed));
        rd_reg(SAFP_A_STAT, d);
        chk("tx full", 32'h6, d);
        wr_reg(SAFP_A_CTRL, 32'h100);
        rd_reg(SAFP_A_STAT, d);
        chk("tx clear", 32'h5, d);
        // Slave link: two 16-bit channels each way in a 32-bit frame
        wr_reg(SAFP_A_FRAME, 32'h1f);
        wr_reg(SAFP_A_TXCH, 32'hbc10bc00);
        wr_reg(SAFP_A_RXCH, 32'hbc10bc00);
        for (k = 0; k < DEPTH; k++) begin
            x = $random(seed);
            exp_tx.push_back(x);
            wr_reg(SAFP_A_DATA, x);
        end
        wr_reg(SAFP_A_CTRL, 32'h1f);
        run <= 1'b1;
        for (k = 0; k < 6000 && frames < 16'd6; k++) @(posedge sys_clk);
        run <= 1'b0;
        chk("tx sent", 32'h0, 32'(exp_tx.size()));
        rd_reg(SAFP_A_STAT, d);
        chk("errors kept", 32'h39, d & 32'h3f);
        chk("rx request", 32'h1, {31'h0, rx_req});
        m = 0;
        rd_reg(SAFP_A_DATA, d);
        while (exp_rx.size() > DEPTH && {16'h0, exp_rx[0]} !== d) begin
            void'(exp_rx.pop_front());
            m++;
        end
        chk("rx pairing", 32'h0, 32'(m % 2));
        for (k = 0; k < DEPTH; k++) begin
            if (k > 0) rd_reg(SAFP_A_DATA, d);
            chk("rx word", {16'h0, exp_rx.pop_front()}, d);
        end
        rd_reg(SAFP_A_DATA, d);
        chk("rx drained", 32'h0, d);
        wr_reg(SAFP_A_CTRL, 32'h0);
        wr_reg(SAFP_A_STAT, 32'h30);
        rd_reg(SAFP_A_STAT, d);
        chk("errors cleared", 32'h5, d);
        // Master link with empty tx queue
        wr_reg(SAFP_A_FRAME, 32'h41f);
        wr_reg(SAFP_A_CTRL, 32'h3);
        repeat (2) @(negedge sys_clk);
        chk("master enables", 32'h0, {30'h0, bclk_oe_n, fs_oe_n});
        chk("service levels", 32'h2, {30'h0, tx_req, rx_req});
        {n_bclk, n_fs, n_dout} = '0;
        repeat (1280) @(posedge sys_clk);
        chk("bclk rate", 32'h1, 32'(n_bclk >= 62 && n_bclk <= 66));
        chk("sync pulses", 32'h1, 32'(n_fs >= 1 && n_fs <= 3));
        chk("zeros sent", 32'h0, 32'(n_dout));
        // Slave clock inverted, density-modulated input on both edges for one frame
        wr_reg(SAFP_A_CTRL, 32'h0);
        wr_reg(SAFP_A_CTRL, 32'had);
        x = c_tx;
        m = frames;
        run <= 1'b1;
        wait (frames != 16'(m));
        run <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd_reg(SAFP_A_DATA, d);
        chk("pdm ch1", x, d);
        rd_reg(SAFP_A_DATA, d);
        chk("pdm ch2", x, d);
        tally_and_finish();
    end
endmodule
`default_nettype wire
